/* rtl/pcdpll_params.svh */
// Constants of the PCM receive clock loop: offsets, fields, resets, counts
`ifndef PCDPLL_PARAMS_SVH
`define PCDPLL_PARAMS_SVH

// ****************************************************
// Register offsets on the processor write port
// ****************************************************
`define PCDPLL_ADDR_FRAC_LO   8'hd5
`define PCDPLL_ADDR_FRAC_HI   8'hd6
`define PCDPLL_ADDR_INT_DIV   8'hd7
`define PCDPLL_ADDR_GAINS     8'hd8
`define PCDPLL_ADDR_PH_START  8'hdb
`define PCDPLL_ADDR_RX_RESET  8'hf1
`define PCDPLL_ADDR_PD_RESTART 8'hf6

// ****************************************************
// Field positions of the gain register
// ****************************************************
`define PCDPLL_PGAIN_MSB      6
`define PCDPLL_PGAIN_LSB      4
`define PCDPLL_ICOEF_MSB      3
`define PCDPLL_ICOEF_LSB      0

// ****************************************************
// Reset values
// ****************************************************
`define PCDPLL_RST_FRAC       16'h0000
`define PCDPLL_RST_INT_DIV    8'hef
`define PCDPLL_RST_GAINS      7'h00
`define PCDPLL_RST_PH_START   8'h80

// ****************************************************
// Loop constants and counts
// ****************************************************
`define PCDPLL_INT_BASE       9'h101
`define PCDPLL_MIN_HALF_INT   9'h002
`define PCDPLL_WIN_LAST       10'h3ff
`define PCDPLL_WIN_CENTER     10'h200
`define PCDPLL_PGAIN_BASE     4'h5
`define PCDPLL_ICOEF_MAXPOW   4'h9
`define PCDPLL_ICOEF_SATSH    4'ha
`define PCDPLL_ICOEF_TYPE1    4'hf
`define PCDPLL_ICOEF_FRACB    4
`define PCDPLL_CORR_SHIFT     16

`endif

/* rtl/pcdpll_pkg.sv */
// Types shared by the PCM receive clock loop modules
package pcdpll_pkg;

  // Half period of the receive clock in reference cycles
  typedef struct packed {
    logic [8:0]  whole;
    logic [15:0] frac;
  } pcdpll_period_t;

  // One processor write
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pcdpll_wr_t;

  // Phase detector states
  typedef enum logic [0:0] {
    PCDPLL_PD_RUN,
    PCDPLL_PD_ERR
  } pcdpll_pd_state_t;

endpackage

/* rtl/pcdpll_nco.sv */
// Fractional divider that toggles the receive clock every half period
`timescale 1ns/1ps
`include "pcdpll_params.svh"

module pcdpll_nco
  import pcdpll_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_b,
  input  wire pcdpll_period_t i_half,
  output logic                o_clk,
  output logic                o_edge
);

  logic [8:0]  cnt_reg;
  logic [8:0]  cnt_next;
  logic [15:0] facc_reg;
  logic [15:0] facc_next;
  logic        clk_reg;
  logic        edge_reg;
  logic [16:0] fsum;
  wire         last_cycle;

  // ****************************************************
  // Whole cycles plus a carry from the fraction sum
  // ****************************************************
  assign last_cycle = (cnt_reg <= 9'h001);
  assign fsum       = {1'b0, facc_reg} + {1'b0, i_half.frac};
  assign facc_next  = last_cycle ? fsum[15:0] : facc_reg;
  assign cnt_next   = last_cycle ? i_half.whole + {8'h00, fsum[16]}
                                 : cnt_reg - 9'h001;

  // Counter, fraction and clock flops
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_reg  <= `PCDPLL_MIN_HALF_INT;
      facc_reg <= 16'h0000;
      clk_reg  <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      facc_reg <= facc_next;
      clk_reg  <= clk_reg ^ last_cycle;
      edge_reg <= last_cycle & ~clk_reg;
    end
  end

  assign o_clk  = clk_reg;
  assign o_edge = edge_reg;

endmodule // pcdpll_nco

/* rtl/pcdpll_top.sv */
// PCM receive clock loop: registers, phase detector, filter and divider
`timescale 1ns/1ps
`include "pcdpll_params.svh"

module pcdpll_top
  import pcdpll_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_mpu_wr,
  input  wire logic [7:0]  i_mpu_addr,
  input  wire logic [7:0]  i_mpu_wdata,
  input  wire logic [3:0]  i_pll_scale_div,
  input  wire logic        i_loop_open_closed_select,
  input  wire logic        i_phase_init_select,
  input  wire logic        i_fast_acquisition,
  input  wire logic        i_master_framer_in_sync,
  input  wire logic        i_ref_frame,
  output logic             o_pcm_rx_clk,
  output logic             o_phase_error,
  output logic             o_loop_error_pending,
  output logic [10:0]      o_phase_offset
);

  // ****************************************************
  // Decode helpers
  // ****************************************************

  // Proportional shift: code 0 gives 2^5, code 7 gives 2^12
  function automatic logic [3:0] f_prop_shift(input logic [2:0] code);
    f_prop_shift = `PCDPLL_PGAIN_BASE + {1'b0, code};
  endfunction

  // Integral shift on a value held with four fraction bits
  function automatic logic [3:0] f_integ_shift(input logic [3:0] code);
    if (code > `PCDPLL_ICOEF_MAXPOW) begin
      f_integ_shift = `PCDPLL_ICOEF_SATSH;
    end else begin
      f_integ_shift = code;
    end
  endfunction

  // ****************************************************
  // Register port
  // ****************************************************
  pcdpll_wr_t  wr_bus;
  logic [7:0]  frac_lo_reg;
  logic [7:0]  frac_hi_reg;
  logic [7:0]  int_div_reg;
  logic [6:0]  gains_reg;
  logic [7:0]  ph_start_reg;
  wire         wr_frac_lo;
  wire         wr_frac_hi;
  wire         wr_int_div;
  wire         wr_gains;
  wire         wr_ph_start;
  wire         wr_rx_reset;
  wire         wr_restart;

  // Bundle the write strobe with its address and data
  assign wr_bus = '{wr: i_mpu_wr, addr: i_mpu_addr, data: i_mpu_wdata};

  // Per-register write strobes
  assign wr_frac_lo  = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_FRAC_LO;
  assign wr_frac_hi  = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_FRAC_HI;
  assign wr_int_div  = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_INT_DIV;
  assign wr_gains    = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_GAINS;
  assign wr_ph_start = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_PH_START;
  assign wr_rx_reset = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_RX_RESET;
  assign wr_restart  = wr_bus.wr && wr_bus.addr == `PCDPLL_ADDR_PD_RESTART;

  // Write-only holding registers; residual bytes are only staged here
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      frac_lo_reg  <= 8'(`PCDPLL_RST_FRAC);
      frac_hi_reg  <= 8'(`PCDPLL_RST_FRAC >> 8);
      int_div_reg  <= `PCDPLL_RST_INT_DIV;
      gains_reg    <= `PCDPLL_RST_GAINS;
      ph_start_reg <= `PCDPLL_RST_PH_START;
    end else begin
      if (wr_frac_lo)  frac_lo_reg  <= wr_bus.data;
      if (wr_frac_hi)  frac_hi_reg  <= wr_bus.data;
      if (wr_int_div)  int_div_reg  <= wr_bus.data;
      if (wr_gains)    gains_reg    <= wr_bus.data[6:0];
      if (wr_ph_start) ph_start_reg <= wr_bus.data;
    end
  end

  // ****************************************************
  // Residual load on receive reset or framer lock
  // ****************************************************
  logic        sync_d_reg;
  logic [15:0] frac_act_reg;
  wire         lock_rise;
  wire         load_resid;

  assign lock_rise  = i_master_framer_in_sync & ~sync_d_reg;
  assign load_resid = wr_rx_reset | lock_rise;

  // Active residual used by the divider
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sync_d_reg   <= 1'b0;
      frac_act_reg <= `PCDPLL_RST_FRAC;
    end else begin
      sync_d_reg <= i_master_framer_in_sync;
      if (load_resid) begin
        frac_act_reg <= {frac_hi_reg, frac_lo_reg};
      end
    end
  end

  // ****************************************************
  // Quantizing tick from the reference clock
  // ****************************************************
  logic [3:0] qdiv_reg;
  wire        q_tick;
  wire [3:0]  qdiv_last;

  assign qdiv_last = (i_pll_scale_div == 4'h0) ? 4'h0
                                               : i_pll_scale_div - 4'h1;
  assign q_tick    = (qdiv_reg >= qdiv_last);

  // Free-running scale divider, not tied to any channel clock
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      qdiv_reg <= 4'h0;
    end else begin
      qdiv_reg <= q_tick ? 4'h0 : qdiv_reg + 4'h1;
    end
  end

  // ****************************************************
  // Phase detector
  // ****************************************************
  pcdpll_pd_state_t pd_state_reg;
  pcdpll_pd_state_t pd_state_next;
  logic [9:0]  win_reg;
  logic [9:0]  win_next;
  logic [10:0] phase_reg;
  logic        sample_reg;
  logic        pend_reg;
  wire  [9:0]  start_point;
  wire         win_over;
  wire         pd_err_evt;
  wire         auto_exit;
  wire  [10:0] phase_now;

  // Manual start is the register times four, automatic is the centre
  assign start_point = i_phase_init_select ? {ph_start_reg, 2'b00}
                                           : `PCDPLL_WIN_CENTER;
  assign win_over   = q_tick && win_reg == `PCDPLL_WIN_LAST;
  assign pd_err_evt = (pd_state_reg == PCDPLL_PD_RUN) && win_over
                      && !i_ref_frame;
  assign auto_exit  = !i_phase_init_select && !i_fast_acquisition;
  assign phase_now  = {1'b0, win_reg} - {1'b0, `PCDPLL_WIN_CENTER};

  // Window position: restart, reference capture, error, or count
  always_comb begin
    win_next = win_reg;
    if (wr_restart || i_ref_frame || win_over) begin
      win_next = start_point;
    end else if (q_tick) begin
      win_next = win_reg + 10'h001;
    end
  end

  // Error state: left by restart, or on a reference when automatic and not fast acquiring
  always_comb begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      PCDPLL_PD_RUN: begin
        // A restart in the same cycle keeps the error output clear
        if (pd_err_evt && !wr_restart) begin
          pd_state_next = PCDPLL_PD_ERR;
        end
      end
      PCDPLL_PD_ERR: begin
        if (wr_restart) begin
          pd_state_next = PCDPLL_PD_RUN;
        end else if (auto_exit && i_ref_frame) begin
          pd_state_next = PCDPLL_PD_RUN;
        end
      end
      default: pd_state_next = PCDPLL_PD_RUN;
    endcase
  end

  // Detector flops; a new error beats a restart in the same cycle for the pending flag
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pd_state_reg <= PCDPLL_PD_RUN;
      win_reg      <= `PCDPLL_WIN_CENTER;
      phase_reg    <= 11'h000;
      sample_reg   <= 1'b0;
      pend_reg     <= 1'b0;
    end else begin
      pd_state_reg <= pd_state_next;
      win_reg      <= win_next;
      sample_reg   <= i_ref_frame && pd_state_reg == PCDPLL_PD_RUN;
      if (i_ref_frame) phase_reg <= phase_now;
      if (pd_err_evt) begin
        pend_reg <= 1'b1;
      end else if (wr_restart) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Loop filter
  // ****************************************************
  logic signed [31:0] integ_reg;
  wire  signed [31:0] phase_s;
  wire  signed [31:0] prop_term;
  wire  signed [31:0] integ_step;
  wire  signed [31:0] corr_sum;
  wire  signed [31:0] corr;
  wire         [2:0]  pgain_code;
  wire         [3:0]  icoef_code;
  wire                type_one;

  assign pgain_code = gains_reg[`PCDPLL_PGAIN_MSB:`PCDPLL_PGAIN_LSB];
  assign icoef_code = gains_reg[`PCDPLL_ICOEF_MSB:`PCDPLL_ICOEF_LSB];
  assign type_one   = (icoef_code == `PCDPLL_ICOEF_TYPE1);
  assign phase_s    = {{21{phase_reg[10]}}, phase_reg};
  assign prop_term  = phase_s <<< f_prop_shift(pgain_code);
  assign integ_step = phase_s <<< f_integ_shift(icoef_code);
  assign corr_sum   = prop_term + (integ_reg >>> `PCDPLL_ICOEF_FRACB);
  assign corr       = corr_sum >>> `PCDPLL_CORR_SHIFT;

  // Integrator; cleared on residual load so the start rate is exact
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      integ_reg <= 32'sh0;
    end else if (load_resid || type_one || !i_loop_open_closed_select) begin
      integ_reg <= 32'sh0;
    end else if (sample_reg) begin
      integ_reg <= integ_reg + integ_step;
    end
  end

  // ****************************************************
  // Divider period and receive clock
  // ****************************************************
  pcdpll_period_t half_period;
  logic signed [31:0] corr_reg;
  wire  [8:0]  half_whole;
  wire  signed [31:0] base_per;
  wire  signed [31:0] eff_per;
  wire  signed [31:0] min_per;

  // Whole half-period cycles are 257 minus the divisor register
  assign half_whole = `PCDPLL_INT_BASE - {1'b0, int_div_reg};
  assign base_per   = {7'h00, half_whole, frac_act_reg};
  assign min_per    = {7'h00, `PCDPLL_MIN_HALF_INT, 16'h0000};
  assign eff_per    = i_loop_open_closed_select ? base_per + corr_reg
                                                : base_per;
  assign half_period = (eff_per < min_per) ? min_per[24:0]
                                           : eff_per[24:0];

  // Correction holds between phase samples
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      corr_reg <= 32'sh0;
    end else if (load_resid || !i_loop_open_closed_select) begin
      corr_reg <= 32'sh0;
    end else if (sample_reg) begin
      corr_reg <= corr;
    end
  end

  // Divider runs straight off the reference clock
  pcdpll_nco u_nco (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_half    (half_period),
    .o_clk     (o_pcm_rx_clk),
    .o_edge    ()
  );

  // ****************************************************
  // Status outputs
  // ****************************************************
  assign o_phase_error        = (pd_state_reg == PCDPLL_PD_ERR);
  assign o_loop_error_pending = pend_reg;
  assign o_phase_offset       = phase_reg;

endmodule // pcdpll_top

/* dv/pcdpll_framer_model.sv */
// Framer model that times the recovered receive clock
`timescale 1ns/1ps

module pcdpll_framer_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_rx_clk,
  output int        o_half,
  output int        o_edges
);
  logic prev_reg;
  int   cnt_reg;

  // Count reference cycles between receive clock edges
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      prev_reg <= 1'b0;
      cnt_reg  <= 0;
      o_half   <= 0;
      o_edges  <= 0;
    end else begin
      prev_reg <= i_rx_clk;
      if (i_rx_clk != prev_reg) begin
        o_half  <= cnt_reg + 1;
        o_edges <= o_edges + 1;
        cnt_reg <= 0;
      end else begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
endmodule // pcdpll_framer_model

/* dv/pcdpll_top_monitor.sv */
// Port checker of the receive clock loop
`timescale 1ns/1ps
`include "pcdpll_params.svh"

module pcdpll_top_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_mpu_wr,
  input wire logic [7:0]  i_mpu_addr,
  input wire logic [7:0]  i_mpu_wdata,
  input wire logic [3:0]  i_pll_scale_div,
  input wire logic        i_loop_open_closed_select,
  input wire logic        i_phase_init_select,
  input wire logic        i_fast_acquisition,
  input wire logic        i_master_framer_in_sync,
  input wire logic        i_ref_frame,
  input wire logic        o_pcm_rx_clk,
  input wire logic        o_phase_error,
  input wire logic        o_loop_error_pending,
  input wire logic [10:0] o_phase_offset
);
  // Restart strobe decode
  wire restart_wr = i_mpu_wr && (i_mpu_addr == `PCDPLL_ADDR_PD_RESTART);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  AST_RST_OUT: assert property (disable iff (1'b0) !i_rst_b |=>
    !o_pcm_rx_clk && !o_phase_error && !o_loop_error_pending
    && o_phase_offset == 11'h000) else $error("outputs not cleared");
  AST_RESTART_CLR: assert property (
    restart_wr |=> !o_phase_error) else $error("restart left error");
  AST_PEND_STICKY: assert property (
    o_loop_error_pending && !restart_wr |=> o_loop_error_pending)
    else $error("pending flag dropped");
  AST_ERR_PEND: assert property (
    $rose(o_phase_error) |-> o_loop_error_pending)
    else $error("error without pending");
  AST_ERR_HOLD: assert property (
    o_phase_error && (i_fast_acquisition || i_phase_init_select)
    && !restart_wr |=> o_phase_error) else $error("error left early");
  AST_ERR_LEAVE: assert property (
    o_phase_error && i_ref_frame && !i_phase_init_select
    && !i_fast_acquisition |=> !o_phase_error)
    else $error("error kept after ref");
  AST_OFF_HOLD: assert property (
    !i_ref_frame |=> $stable(o_phase_offset)) else $error("offset moved");
  AST_OFF_SPAN: assert property (
    o_phase_offset[10] == o_phase_offset[9]) else $error("offset span");
  AST_ERR_NO_REF: assert property (
    $rose(o_phase_error) |-> !$past(i_ref_frame))
    else $error("error with ref pulse");
  AST_HALF_MIN: assert property (
    $changed(o_pcm_rx_clk) |=> $stable(o_pcm_rx_clk))
    else $error("half period below two");
endmodule // pcdpll_top_monitor

bind pcdpll_top pcdpll_top_monitor mon_u (.i_sys_clk, .i_rst_b,
  .i_mpu_wr, .i_mpu_addr, .i_mpu_wdata, .i_pll_scale_div,
  .i_loop_open_closed_select, .i_phase_init_select, .i_fast_acquisition,
  .i_master_framer_in_sync, .i_ref_frame, .o_pcm_rx_clk, .o_phase_error,
  .o_loop_error_pending, .o_phase_offset);

/* dv/pcdpll_top_tb.sv */
// Self-checking bench of the receive clock loop
`timescale 1ns/1ps
`include "pcdpll_params.svh"

module pcdpll_top_tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_mpu_wr = 1'b0;
  logic [7:0]  i_mpu_addr = 8'h00;
  logic [7:0]  i_mpu_wdata = 8'h00;
  logic [3:0]  i_pll_scale_div = 4'h1;
  logic        i_loop_open_closed_select = 1'b0;
  logic        i_phase_init_select = 1'b0;
  logic        i_fast_acquisition = 1'b0;
  logic        i_master_framer_in_sync = 1'b0;
  logic        i_ref_frame = 1'b0;
  logic        o_pcm_rx_clk;
  logic        o_phase_error;
  logic        o_loop_error_pending;
  logic [10:0] o_phase_offset;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          half_len;
  int          edges;
  int          s;
  int          n;
  logic signed [15:0] a;
  logic signed [15:0] b;
  logic signed [15:0] base;

  // Reference clock, 25 ns period
  always #12.5 i_sys_clk = ~i_sys_clk;

  pcdpll_top dut_u (.i_sys_clk, .i_rst_b, .i_mpu_wr, .i_mpu_addr,
    .i_mpu_wdata, .i_pll_scale_div, .i_loop_open_closed_select,
    .i_phase_init_select, .i_fast_acquisition, .i_master_framer_in_sync,
    .i_ref_frame, .o_pcm_rx_clk, .o_phase_error, .o_loop_error_pending,
    .o_phase_offset);

  pcdpll_framer_model frm_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_rx_clk(o_pcm_rx_clk), .o_half(half_len), .o_edges(edges));

  // ****************************************************
  // Access and compare tasks
  // ****************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_eq(input logic [15:0] got, input int exp, input string w);
    checked++;
    if (got !== exp[15:0]) begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, w, got, exp);
    end
  endtask

  task automatic chk_rng(input logic signed [15:0] got, input int lo,
                         input int hi, input string w);
    checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t %s got %0d", $time, w, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #2;
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
    tick(1);
    i_mpu_wr = 1'b1;
    i_mpu_addr = ad;
    i_mpu_wdata = dt;
    tick(1);
    i_mpu_wr = 1'b0;
  endtask

  task automatic pulse();
    tick(1);
    i_ref_frame = 1'b1;
    tick(1);
    i_ref_frame = 1'b0;
  endtask

  // Offset captured by a ref pulse d+2 cycles after the previous one
  task automatic off_after(input int d, output logic signed [15:0] off);
    pulse();
    tick(d);
    pulse();
    tick(1);
    off = {{5{o_phase_offset[10]}}, o_phase_offset};
  endtask

  // Sum of k half periods, the first two skipped
  task automatic measure(input int k, output int sum);
    int seen;
    int last;
    int lim;
    seen = 0;
    sum = 0;
    lim = 0;
    last = edges;
    while (seen < k + 2 && lim < 2000) begin
      tick(1);
      lim++;
      if (edges != last) begin
        if (seen >= 2) sum += half_len;
        seen++;
        last = edges;
      end
    end
  endtask

  task automatic wait_err(output int k);
    k = 0;
    while (o_phase_error !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
  endtask

  // Cut a hang short
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("[ERR] %0t run did not finish", $time);
      give_verdict();
    end
  end

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    tick(8);
    i_rst_b = 1'b1;
    tick(1);
    chk_eq({o_pcm_rx_clk, o_phase_error, o_loop_error_pending,
            o_phase_offset}, 0, "reset outputs");
    measure(4, s);
    chk_eq(16'(s), 4 * (257 - 'hef), "default rate");
    $display("test reset done");

    wr_reg(`PCDPLL_ADDR_INT_DIV, 8'hfd);
    measure(8, s);
    chk_eq(16'(s), 8 * (257 - 'hfd), "divisor rate");
    wr_reg(`PCDPLL_ADDR_FRAC_LO, 8'h00);
    wr_reg(`PCDPLL_ADDR_FRAC_HI, 8'h80);
    wr_reg(8'hd9, 8'h01);
    measure(8, s);
    chk_eq(16'(s), 32, "staged residual");
    wr_reg(`PCDPLL_ADDR_RX_RESET, 8'h00);
    measure(8, s);
    chk_rng(16'(s), 35, 37, "residual loaded");
    wr_reg(`PCDPLL_ADDR_FRAC_HI, 8'h00);
    i_master_framer_in_sync = 1'b1;
    measure(8, s);
    chk_eq(16'(s), 32, "sync load");
    i_master_framer_in_sync = 1'b0;
    $display("test rate done");

    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'h00);
    off_after(38, base);
    chk_rng(base, 38, 41, "offset position");
    off_after(98, b);
    chk_eq(b - base, 60, "offset slope");
    i_pll_scale_div = 4'h4;
    off_after(38, a);
    off_after(98, b);
    chk_rng(b - a, 14, 16, "quantizing slope");
    i_pll_scale_div = 4'h1;
    i_phase_init_select = 1'b1;
    wr_reg(`PCDPLL_ADDR_PH_START, 8'h40);
    off_after(38, b);
    chk_eq(base - b, 256, "manual start");
    wr_reg(`PCDPLL_ADDR_PH_START, 8'h80);
    off_after(38, b);
    chk_eq(b - base, 0, "centre start");
    $display("test phase done");

    i_phase_init_select = 1'b0;
    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'h5a);
    wait_err(n);
    chk_rng(16'(n), 508, 514, "window length");
    pulse();
    tick(1);
    chk_eq({o_phase_error, o_loop_error_pending}, 1, "auto leave");
    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'hff);
    chk_eq({o_phase_error, o_loop_error_pending}, 0, "restart");
    i_fast_acquisition = 1'b1;
    wait_err(n);
    pulse();
    chk_eq(o_phase_error, 1, "fast hold");
    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'h00);
    chk_eq(o_phase_error, 0, "fast restart");
    i_fast_acquisition = 1'b0;
    i_phase_init_select = 1'b1;
    wr_reg(`PCDPLL_ADDR_PH_START, 8'hfa);
    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'h00);
    wait_err(n);
    chk_rng(16'(n), 20, 26, "manual window");
    pulse();
    tick(1);
    a = {{5{o_phase_offset[10]}}, o_phase_offset};
    chk_rng(a, 488, 494, "return to start");
    chk_eq(o_phase_error, 1, "manual hold");
    wr_reg(`PCDPLL_ADDR_PD_RESTART, 8'h00);
    $display("test error done");

    i_phase_init_select = 1'b0;
    i_loop_open_closed_select = 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr_reg(`PCDPLL_ADDR_GAINS, 8'((i % 8) * 16 + i));
      pulse();
    end
    measure(8, s);
    chk_rng(16'(s), 31, 33, "closed loop rate");
    i_loop_open_closed_select = 1'b0;
    $display("test gains done");
    give_verdict();
  end
endmodule // pcdpll_top_tb
